// [hdl/dec_core.sv]
// Dual encoder counter core with reference counter and capture FIFOs
`timescale 1ns/1ps
`include "dec_defs.svh"

// Flip-flop FIFO with valid/ready on both sides
module dec_fifo #(
    parameter int W = 32,
    parameter int D = 32
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Fill side
    input wire logic i_in_valid,
    input wire logic [W-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side
    output logic o_out_valid,
    output logic [W-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    localparam logic [AW-1:0] LAST = AW'(D - 1);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } dec_fifo_st_s;
    dec_fifo_st_s s, next_s;
    logic push, pop;

    // Handshakes and head word
    assign o_in_ready = (s.cnt != FULL);
    assign o_out_valid = (s.cnt != '0);
    assign o_out_data = s.mem[s.rp];
    assign push = i_in_valid & o_in_ready;
    assign pop = i_out_ready & o_out_valid;

    // Pointer and count update
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = i_in_data;
            next_s.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// Function
// - Differential inputs; index resets the count
// - Reads at 0 and 4 pop FIFOs
// - Count readable only through capture FIFO
// - Main counters and data are 32 bits
// - Evaluation field: 1x, 2x, 4x, events
// - Capture source: software, reference, input 0
// - Function: incremental or timed on 5/10 MHz
// - Direction bit reverses count sense
// - Polarity bit selects active index level
// - Run bit starts or stops counter
// - Reference counter may reset main counters
// - Bit 22 picks input 0 edge
// - Reference evaluation field at bits 27:26
// - Reference direction at bit 28
// - Reference index polarity at bit 29
// - Reference function: increments or periodic timer
// - Reference run control at bit 31
// - Digital inputs active high
// - Each main counter has 32-deep FIFO
// - Reference triggers each step after index
// - Timer rate 20 kHz over divider
// - Software latch pushes value into FIFO
module dec_core import dec_pkg::*; (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Register port of the function I/O range
    input wire dec_bus_s i_bus,
    output logic [31:0] o_rdata,
    output logic o_rack,
    // Encoders: two main counters, then the reference counter
    input wire dec_enc_s [2:0] i_enc,
    // Digital inputs
    input wire logic [3:0] i_din
);
    localparam logic [10:0] PRE_LAST = 11'(`DEC_REF_CYC - 1);
    localparam logic [2:0] TB_SLOW = 3'(`DEC_TB_SLOW_CYC - 1);
    localparam logic [1:0] TB_FAST = 2'(`DEC_TB_FAST_CYC - 1);

    dec_state_s s, next_s;
    logic [2:0] lvl_a, lvl_b, zact, step, up;
    logic [1:0] cap, f_ready, f_valid, f_pop;
    logic [1:0][31:0] f_data;

    // Per-encoder receive and quadrature decode
    for (genvar i = 0; i < 3; i++) begin : g_dec
        localparam int EB = (i == 2) ? `DEC_F_REVAL : i * `DEC_STRIDE + `DEC_F_EVAL;
        localparam int DB = (i == 2) ? `DEC_F_RDIR : i * `DEC_STRIDE + `DEC_F_DIR;
        localparam int PB = (i == 2) ? `DEC_F_RPOL : i * `DEC_STRIDE + `DEC_F_POL;
        logic ea, eb, raw_up;
        // Differential pair reads high when the true line is above its mate
        assign lvl_a[i] = i_enc[i].a_p & ~i_enc[i].a_n;
        assign lvl_b[i] = i_enc[i].b_p & ~i_enc[i].b_n;
        assign zact[i] = (i_enc[i].z_p & ~i_enc[i].z_n) ^ s.mode[PB];
        assign ea = lvl_a[i] ^ s.pa[i];
        assign eb = lvl_b[i] ^ s.pb[i];
        // Edge selection per evaluation code
        always_comb begin
            case (s.mode[EB +: 2])
                `DEC_EV_1X: begin
                    step[i] = ea & lvl_a[i];
                    raw_up = ~lvl_b[i];
                end
                `DEC_EV_2X: begin
                    step[i] = ea;
                    raw_up = lvl_a[i] ^ lvl_b[i];
                end
                `DEC_EV_4X: begin
                    step[i] = ea | eb;
                    raw_up = lvl_a[i] ^ s.pb[i];
                end
                default: begin
                    step[i] = ea & lvl_a[i];
                    raw_up = 1'b1;
                end
            endcase
        end
        assign up[i] = raw_up ^ s.mode[DB];
    end

    // Capture FIFOs, one per main counter
    for (genvar c = 0; c < 2; c++) begin : g_fifo
        dec_fifo #(
            .W(32),
            .D(`DEC_FIFO_DEPTH)
        ) u_fifo (
            .i_clk_sys(i_clk_sys),
            .i_nrst(i_nrst),
            .i_in_valid(cap[c]),
            .i_in_data(s.cnt[c]),
            .o_in_ready(f_ready[c]),
            .o_out_valid(f_valid[c]),
            .o_out_data(f_data[c]),
            .i_out_ready(f_pop[c])
        );
    end

    assign o_rdata = s.rdata;
    assign o_rack = s.rack;

    // Next-state logic of the whole core
    always_comb begin
        logic ref_trig, din_trig, tb_tick, rrun;
        logic [1:0] src, fn;
        logic [15:0] div_eff;
        int b;
        next_s = s;
        ref_trig = 1'b0;
        din_trig = 1'b0;
        tb_tick = 1'b0;
        src = '0;
        fn = '0;
        b = 0;
        cap = '0;
        f_pop = '0;
        rrun = s.mode[`DEC_F_RRUN];
        div_eff = (s.div == '0) ? `DEC_DIV_RST : s.div;
        next_s.pa = lvl_a;
        next_s.pb = lvl_b;
        next_s.tb = s.tb + 1'b1;
        next_s.din0_q = i_din[0];
        next_s.rack = i_bus.rd;
        // Input 0 edge, rising or falling as picked by bit 22
        din_trig = s.mode[`DEC_F_DEDGE] ? (s.din0_q & ~i_din[0])
                                       : (~s.din0_q & i_din[0]);
        // Reference counter: counts steps or times periods
        if (rrun) begin
            if (s.mode[`DEC_F_RFN]) begin
                next_s.pre = (s.pre == PRE_LAST) ? '0 : s.pre + 1'b1;
                if (s.pre == PRE_LAST) begin
                    if (s.dcnt >= div_eff - 16'h0001) begin
                        next_s.dcnt = '0;
                        ref_trig = 1'b1;
                    end else begin
                        next_s.dcnt = s.dcnt + 1'b1;
                    end
                end
            end else begin
                ref_trig = s.rarm & step[2];
                if (step[2]) begin
                    next_s.rcnt = up[2] ? s.rcnt + 1'b1 : s.rcnt - 1'b1;
                end
            end
            if (zact[2]) begin
                next_s.rcnt = '0;
                next_s.rarm = 1'b1;
            end
        end else begin
            next_s.pre = '0;
            next_s.dcnt = '0;
        end
        // Main counters
        for (int c = 0; c < 2; c++) begin
            b = c * `DEC_STRIDE;
            src = s.mode[b + `DEC_F_SRC +: 2];
            fn = s.mode[b + `DEC_F_FN +: 2];
            tb_tick = fn[0] ? (s.tb[1:0] == TB_FAST) : (s.tb == TB_SLOW);
            if (s.mode[b + `DEC_F_RUN]) begin
                case (src)
                    `DEC_SRC_REF: cap[c] = ref_trig;
                    `DEC_SRC_DIN: cap[c] = din_trig;
                    default: cap[c] = 1'b0;
                endcase
                if (fn[1]) begin
                    // Time between steps: store and restart on each step; a tick in
                    // the step cycle opens the new interval so no tick is lost
                    cap[c] = cap[c] | step[c];
                    next_s.cnt[c] = step[c] ? 32'(tb_tick) : s.cnt[c] + 32'(tb_tick);
                end else if (step[c]) begin
                    next_s.cnt[c] = up[c] ? s.cnt[c] + 1'b1 : s.cnt[c] - 1'b1;
                end
                if (zact[c]) begin
                    next_s.cnt[c] = '0;
                end
                if (s.mode[b + `DEC_F_RRST] && rrun && zact[2]) begin
                    next_s.cnt[c] = '0;
                end
            end
            // Software latch, written as bit c at the status offset
            if (i_bus.wr && i_bus.addr == `DEC_A_STAT && i_bus.wdata[c]) begin
                cap[c] = 1'b1;
            end
            if (cap[c] && !f_ready[c]) begin
                next_s.ovf[c] = 1'b1;
            end
        end
        // Register writes
        if (i_bus.wr) begin
            case (i_bus.addr)
                `DEC_A_CNT1: next_s.cnt[0] = i_bus.wdata;
                `DEC_A_CNT2: next_s.cnt[1] = i_bus.wdata;
                `DEC_A_MODE: next_s.mode = i_bus.wdata;
                `DEC_A_DIV: next_s.div = i_bus.wdata[15:0];
                default: ;
            endcase
        end
        // Register reads, answered one cycle later
        next_s.rdata = '0;
        if (i_bus.rd) begin
            case (i_bus.addr)
                `DEC_A_CNT1: begin
                    f_pop[0] = f_valid[0];
                    next_s.rdata = f_valid[0] ? f_data[0] : 32'h0;
                end
                `DEC_A_CNT2: begin
                    f_pop[1] = f_valid[1];
                    next_s.rdata = f_valid[1] ? f_data[1] : 32'h0;
                end
                `DEC_A_MODE: next_s.rdata = s.mode;
                `DEC_A_DIV: next_s.rdata = {16'h0, s.div};
                `DEC_A_STAT: begin
                    for (int c = 0; c < 2; c++) begin
                        b = c * `DEC_STRIDE;
                        next_s.rdata[b + `DEC_S_RUN] = s.mode[b + `DEC_F_RUN];
                        next_s.rdata[b + `DEC_S_NEMPTY] = f_valid[c];
                        next_s.rdata[b + `DEC_S_OVF] = s.ovf[c];
                        // Read clears overflow unless a new one lands now
                        next_s.ovf[c] = cap[c] & ~f_ready[c];
                    end
                end
                default: next_s.rdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            s <= '0;
            s.div <= `DEC_DIV_RST;
        end else begin
            s <= next_s;
        end
    end
endmodule

// [hdl/dec_defs.svh]
// Register map, field positions and timing counts of the dual encoder counter core
`ifndef DEC_DEFS_SVH
`define DEC_DEFS_SVH
`define DEC_A_CNT1 5'h00
`define DEC_A_CNT2 5'h04
`define DEC_A_MODE 5'h08
`define DEC_A_STAT 5'h0C
`define DEC_A_DIV 5'h18
`define DEC_STRIDE 12
`define DEC_F_EVAL 0
`define DEC_F_SRC 2
`define DEC_F_FN 4
`define DEC_F_DIR 6
`define DEC_F_POL 7
`define DEC_F_RUN 8
`define DEC_F_RRST 9
`define DEC_F_DEDGE 22
`define DEC_F_REVAL 26
`define DEC_F_RDIR 28
`define DEC_F_RPOL 29
`define DEC_F_RFN 30
`define DEC_F_RRUN 31
`define DEC_S_RUN 1
`define DEC_S_NEMPTY 3
`define DEC_S_OVF 4
`define DEC_EV_1X 2'h0
`define DEC_EV_2X 2'h1
`define DEC_EV_4X 2'h2
`define DEC_SRC_REF 2'h2
`define DEC_SRC_DIN 2'h3
`define DEC_CLK_HZ 40000000
`define DEC_TB_FAST_HZ 10000000
`define DEC_TB_SLOW_HZ 5000000
`define DEC_REF_HZ 20000
`define DEC_TB_FAST_CYC (`DEC_CLK_HZ / `DEC_TB_FAST_HZ)
`define DEC_TB_SLOW_CYC (`DEC_CLK_HZ / `DEC_TB_SLOW_HZ)
`define DEC_REF_CYC (`DEC_CLK_HZ / `DEC_REF_HZ)
`define DEC_FIFO_DEPTH 32
`define DEC_DIV_RST 16'h0001
`endif

// [hdl/dec_pkg.sv]
// Types shared by the dual encoder counter core
package dec_pkg;
    // One access of the function I/O range
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [31:0] wdata;
    } dec_bus_s;
    // Differential lead, lag and index pairs of one encoder
    typedef struct packed {
        logic a_p;
        logic a_n;
        logic b_p;
        logic b_n;
        logic z_p;
        logic z_n;
    } dec_enc_s;
    // Whole state of the core
    typedef struct packed {
        logic [31:0] mode;
        logic [15:0] div;
        logic [2:0] pa;
        logic [2:0] pb;
        logic [1:0][31:0] cnt;
        logic [15:0] rcnt;
        logic rarm;
        logic [10:0] pre;
        logic [15:0] dcnt;
        logic [2:0] tb;
        logic din0_q;
        logic [1:0] ovf;
        logic [31:0] rdata;
        logic rack;
    } dec_state_s;
endpackage

// [tb/dec_enc_model.sv]
// Quadrature encoder model with differential lead, lag and index lines
`timescale 1ns/1ps
module dec_enc_model import dec_pkg::*; (
    // Clock
    input wire logic i_clk_sys,
    // Differential encoder lines
    output dec_enc_s o_enc
);
    logic [1:0] ph = 2'h0;
    logic z = 1'b0;
    logic a;
    logic b;
    // Forward sequence of lead and lag: 00, 10, 11, 01
    assign a = ph[1] ^ ph[0];
    assign b = ph[1];
    assign o_enc = {a, ~a, b, ~b, z, ~z};
    // Move the shaft by n quarter steps, four clocks apart
    task automatic step(input int n, input logic fwd);
        repeat (n) begin
            repeat (4) @(posedge i_clk_sys);
            #1 ph = fwd ? ph + 2'h1 : ph - 2'h1;
        end
    endtask
    // Zero position pulse, four clocks long
    task automatic index();
        @(posedge i_clk_sys);
        #1 z = 1'b1;
        repeat (4) @(posedge i_clk_sys);
        #1 z = 1'b0;
    endtask
endmodule

// [tb/dec_core_checker.sv]
// Port-level assertions of the dual encoder counter core
`timescale 1ns/1ps
module dec_core_checker import dec_pkg::*; (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    // Register port and inputs
    input wire dec_bus_s i_bus,
    input wire logic [31:0] o_rdata,
    input wire logic o_rack,
    input wire dec_enc_s [2:0] i_enc,
    input wire logic [3:0] i_din
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    // Read handshake and idle data
    rd_answer_a: assert property (i_bus.rd |=> o_rack)
        else $error("read got no answer");
    no_spurious_a: assert property (o_rack |-> $past(i_bus.rd))
        else $error("answer without a read");
    idle_data_a: assert property (!o_rack |-> o_rdata == 32'h0)
        else $error("read data outside an answer");
    reset_clear_a: assert property (disable iff (1'b0) !i_nrst |=> !o_rack && o_rdata == 32'h0)
        else $error("outputs not cleared by reset");
    unmapped_a: assert property (i_bus.rd && i_bus.addr == 5'h10 |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    // Register contents seen through reads
    mode_back_a: assert property ((i_bus.wr && i_bus.addr == 5'h08) ##1
        (i_bus.rd && i_bus.addr == 5'h08) |=> o_rdata == $past(i_bus.wdata, 2))
        else $error("mode readback differs");
    run_status_a: assert property ((i_bus.wr && i_bus.addr == 5'h08) ##1
        (i_bus.rd && i_bus.addr == 5'h0C) |=> o_rdata[1] == $past(i_bus.wdata[8], 2)
        && o_rdata[13] == $past(i_bus.wdata[20], 2))
        else $error("run status differs from mode");
    latch_status_a: assert property ((i_bus.wr && i_bus.addr == 5'h0C && i_bus.wdata[0])
        ##1 !i_bus.rd ##1 (i_bus.rd && i_bus.addr == 5'h0C) |=> o_rdata[3])
        else $error("latch left first queue empty");
endmodule
bind dec_core dec_core_checker i_chk (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_bus(i_bus),
    .o_rdata(o_rdata), .o_rack(o_rack), .i_enc(i_enc), .i_din(i_din));

// [tb/test_dec_core.sv]
// Register-level testbench of the dual encoder counter core
`timescale 1ns/1ps
module test_dec_core import dec_pkg::*; ;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    dec_bus_s i_bus = '0;
    logic [3:0] i_din = 4'h0;
    logic [31:0] o_rdata;
    logic o_rack;
    wire dec_enc_s [2:0] enc;
    int fail_count = 0;
    int n_compared = 0;
    logic [31:0] rv;
    longint t1;
    longint t2;
    int exp_d[5] = '{2, 4, 8, 2, -8};
    logic [31:0] md[5] = '{32'h100, 32'h101, 32'h102, 32'h103, 32'h142};
    // Clock of 25 ns
    always #12.5 i_clk_sys = ~i_clk_sys;
    // Device and encoders
    dec_core i_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_bus(i_bus), .o_rdata(o_rdata),
        .o_rack(o_rack), .i_enc(enc), .i_din(i_din));
    dec_enc_model i_enc1 (.i_clk_sys(i_clk_sys), .o_enc(enc[0]));
    dec_enc_model i_enc2 (.i_clk_sys(i_clk_sys), .o_enc(enc[1]));
    dec_enc_model i_enc3 (.i_clk_sys(i_clk_sys), .o_enc(enc[2]));
    // Compare one read word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus cycles, entered just after a rising edge; the strobe stays up until
    // the next access replaces it or idle drops it
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        i_bus = '{1'b1, 1'b0, a, d};
        @(posedge i_clk_sys);
        #1;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        i_bus = '{1'b0, 1'b1, a, 32'h0};
        @(posedge i_clk_sys);
        #1;
        d = (o_rack === 1'b1) ? o_rdata : 32'hDEAD_BEEF;
    endtask
    task automatic rc(input logic [4:0] a, input logic [31:0] exp);
        rd(a, rv);
        chk(rv, exp);
    endtask
    task automatic idle(input int n);
        i_bus = '0;
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    // Poll until the first queue holds a value
    task automatic wait_cap(output longint t);
        for (int i = 0; i < 5000; i++) begin
            rd(5'h0C, rv);
            if (rv[3] === 1'b1)
                break;
        end
        t = $time;
        chk({31'h0, rv[3]}, 32'h1);
    endtask
    // Latch counter one and read it back
    task automatic latch_chk(input logic [31:0] exp);
        idle(2);
        wr(5'h0C, 32'h1);
        idle(1);
        rc(5'h00, exp);
    endtask
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        idle(2);
        i_nrst = 1'b1;
        idle(1);
        rc(5'h08, 32'h0);
        rc(5'h18, 32'h1);
        rc(5'h10, 32'h0);
        rc(5'h00, 32'h0);
        wr(5'h08, 32'h5A5A_5A5A);
        rc(5'h08, 32'h5A5A_5A5A);
        wr(5'h08, 32'h0010_0100);
        rc(5'h0C, 32'h0000_2002);
        wr(5'h08, 32'h0);
        wr(5'h00, 32'h8765_4321);
        wr(5'h04, 32'hFFFF_FFFE);
        wr(5'h0C, 32'h3);
        idle(1);
        rc(5'h0C, 32'h0000_8008);
        rc(5'h00, 32'h8765_4321);
        rc(5'h04, 32'hFFFF_FFFE);
        rc(5'h04, 32'h0);
        // Evaluation codes and reversed direction over two full cycles
        for (int i = 0; i < 5; i++) begin
            wr(5'h08, 32'h0);
            wr(5'h00, 32'h100);
            wr(5'h08, md[i]);
            i_enc1.step(8, 1'b1);
            latch_chk(32'(32'h100 + exp_d[i]));
        end
        // Index clears the count; inverted polarity holds it cleared
        wr(5'h08, 32'h0);
        wr(5'h00, 32'h55);
        wr(5'h08, 32'h102);
        i_enc1.step(4, 1'b1);
        i_enc1.index();
        i_enc1.step(4, 1'b1);
        latch_chk(32'h4);
        wr(5'h08, 32'h182);
        i_enc1.step(4, 1'b1);
        latch_chk(32'h0);
        // Input 0 edges capture counter two
        for (int e = 0; e < 2; e++) begin
            wr(5'h08, 32'h0);
            wr(5'h04, 32'h77 + 32'(e));
            wr(5'h08, e ? 32'h0050_C000 : 32'h0010_C000);
            idle(3);
            i_din[0] = 1'b1;
            idle(3);
            i_din[0] = 1'b0;
            idle(3);
            rc(5'h04, 32'h77 + 32'(e));
            rc(5'h04, 32'h0);
        end
        // Time between lead edges on counter two at 5 and 10 MHz
        for (int f = 0; f < 2; f++) begin
            wr(5'h08, f ? 32'h0013_0000 : 32'h0012_0000);
            i_enc2.step(8, 1'b1);
            idle(2);
            // First interval starts at the mode write, or at the last lead edge of the 5 MHz pass when f is 1, so it is dropped
            rd(5'h04, rv);
            rc(5'h04, f ? 32'h4 : 32'h2);
            rc(5'h04, 32'h0);
        end
        // Reference steps trigger only after its index; index clears counter one
        wr(5'h08, 32'h0);
        wr(5'h00, 32'h33);
        wr(5'h08, 32'h8800_0308);
        i_enc3.step(2, 1'b1);
        idle(2);
        rc(5'h0C, 32'h2);
        idle(1);
        i_enc3.index();
        i_enc3.step(1, 1'b1);
        idle(2);
        rc(5'h0C, 32'hA);
        rc(5'h00, 32'h0);
        rc(5'h0C, 32'h2);
        // Reference timer with divider 2 triggers counter one
        wr(5'h08, 32'h0);
        wr(5'h00, 32'h99);
        wr(5'h18, 32'h2);
        wr(5'h08, 32'hC000_0108);
        wait_cap(t1);
        rc(5'h00, 32'h99);
        wait_cap(t2);
        wr(5'h08, 32'h0);
        chk(32'((t2 - t1) / 25), 32'h0000_0FA0);
        rc(5'h00, 32'h99);
        rc(5'h00, 32'h0);
        // Thirty-three captures into a queue of thirty-two
        for (int i = 0; i < 33; i++) begin
            wr(5'h00, 32'(i));
            wr(5'h0C, 32'h1);
        end
        idle(1);
        rc(5'h0C, 32'h18);
        for (int i = 0; i < 32; i++)
            rc(5'h00, 32'(i));
        rc(5'h00, 32'h0);
        final_report();
    end
    // Watchdog
    initial begin
        #1000000;
        fail_count++;
        final_report();
    end
endmodule
